// File: src/stpc_pkg.sv
// stpc_pkg: register map, field positions and timing constants of the slewed coder
// assumes a 100 MHz system clock; the 50 MHz counting rate is an enable pulse
package stpc_pkg;
  // axi4-lite byte offsets, one aligned word each
  localparam logic [7:0] OFF_HOST_CARD = 8'h00;
  localparam logic [7:0] OFF_WRITE_PORT = 8'h04;
  localparam logic [7:0] OFF_READ_PORT = 8'h08;
  localparam logic [7:0] OFF_STRAPS = 8'h0C;
  // host card control fields
  localparam int MODE_LO_BIT = 0;
  localparam int MODE_HI_BIT = 1;
  // coder control fields
  localparam int PTR_LSB = 0;
  localparam int PTR_W = 4;
  localparam int AUTOINC_BIT = 4;
  localparam int CLRINT_BIT = 5;
  localparam int SEL_LSB = 6;
  localparam int MASK_LSB = 9;
  localparam int NUM_CODERS = 4;
  // hold register indices
  localparam logic [3:0] HR_INC_LO = 4'h0;
  localparam logic [3:0] HR_INC_HI = 4'h1;
  localparam logic [3:0] HR_CMP_LO = 4'h2;
  localparam logic [3:0] HR_CMP_HI = 4'h3;
  localparam logic [3:0] HR_DIV_SEL = 4'h4;
  localparam logic [3:0] HR_CODE_SEL = 4'h5;
  localparam logic [3:0] HR_WCNT_LO = 4'h6;
  localparam logic [3:0] HR_WCNT_HI = 4'h7;
  // reset value and default compare reference
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] CMP_REF_DEF = 32'h0098_9680;
  // timing, axi response codes and the write record type
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int COUNT_CLK_HZ = 50_000_000;
  localparam int COUNT_DIV = SYS_CLK_HZ / COUNT_CLK_HZ;
  localparam int CHIP_DIV_NOM = 5;
  localparam int CHIP_DIV_SHORT = 4;
  localparam int CHIP_DIV_LONG = 6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } stpc_wr_t;
endpackage

// File: src/stpc_top.sv
// stpc_top: one slewed coder with its axi4-lite register port
// assumes second_pulse arrives asynchronously on a pin; all else on clk
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module stpc_top #(
  parameter int          CODER_ID = 0,
  parameter logic [31:0] CMP_REF  = stpc_pkg::CMP_REF_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        second_pulse,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             coder_request_line,
  output logic             coder_request_line_oe_n,
  output logic             host_interrupt_first,
  output logic             pn_chip,
  output logic             oversample_strobe
);
  // second pulse synchroniser: stage 1 only feeds stage 2
  logic [2:0] sp_sync_r;
  logic       sp_lvl_r;
  logic       sp_tick;
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_sync_r <= 3'h0;
      sp_lvl_r  <= 1'b0;
    end else begin
      sp_sync_r <= {sp_sync_r[1:0], second_pulse};
      if (sp_sync_r[2] == sp_sync_r[1]) begin
        sp_lvl_r <= sp_sync_r[2];
      end
    end
  end
  assign sp_tick = (sp_sync_r[2] == sp_sync_r[1]) && sp_sync_r[1] && !sp_lvl_r;

  // 50 MHz counting enable
  logic cnt_en_r;
  always_ff @(posedge clk) begin
    if (rst || sp_tick) begin
      cnt_en_r <= 1'b0;
    end else begin
      cnt_en_r <= ~cnt_en_r;
    end
  end

  // registers
  logic [15:0] host_card_control_reg_r;
  logic [15:0] coder_control_reg_r;
  logic [31:0] slew_increment_r;
  logic [31:0] slew_complement_r;
  logic [31:0] inc_act_r;
  logic [31:0] cmp_act_r;
  logic [7:0]  sample_divide_sel_r;
  logic [7:0]  shift_divide_sel_r;
  logic [4:0]  code_len_r;
  logic [31:0] word_count_r;
  logic        irq_r;

  // axi4-lite slave: write takes aw and w in either order
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        wr_go;
  logic        rd_go;
  logic [1:0]  mode;
  logic        ptr_mode;
  logic        ctl_mode;
  logic [3:0]  ptr;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign mode = {host_card_control_reg_r[stpc_pkg::MODE_HI_BIT],
                 host_card_control_reg_r[stpc_pkg::MODE_LO_BIT]};
  assign ctl_mode = (mode == 2'h0);
  assign ptr_mode = (mode == 2'h1);
  assign ptr = coder_control_reg_r[stpc_pkg::PTR_LSB +: stpc_pkg::PTR_W];

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == stpc_pkg::OFF_HOST_CARD) || (a == stpc_pkg::OFF_WRITE_PORT)
              || (a == stpc_pkg::OFF_READ_PORT) || (a == stpc_pkg::OFF_STRAPS);
  endfunction

  logic wr_port;
  logic rd_port;
  assign wr_port = wr_go && (aw_addr_r == stpc_pkg::OFF_WRITE_PORT);
  assign rd_port = rd_go && (s_axi_araddr == stpc_pkg::OFF_READ_PORT);

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= stpc_pkg::AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(aw_addr_r) && (aw_addr_r != stpc_pkg::OFF_READ_PORT)
                      ? stpc_pkg::AXI_OKAY : stpc_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // host card control and coder control; every coder takes the shared write
  always_ff @(posedge clk) begin
    if (rst) begin
      host_card_control_reg_r <= stpc_pkg::CTRL_RST;
      coder_control_reg_r     <= stpc_pkg::CTRL_RST;
    end else begin
      if (wr_go && aw_addr_r == stpc_pkg::OFF_HOST_CARD) begin
        host_card_control_reg_r <= w_data_r[15:0];
      end
      if (wr_port && ctl_mode) begin
        coder_control_reg_r <= w_data_r[15:0];
        coder_control_reg_r[stpc_pkg::CLRINT_BIT] <= 1'b0;
      end else if ((wr_port || rd_port) && ptr_mode
                   && coder_control_reg_r[stpc_pkg::AUTOINC_BIT]) begin
        coder_control_reg_r[stpc_pkg::PTR_LSB +: stpc_pkg::PTR_W] <= ptr + 4'h1;
      end
    end
  end

  // hold register writes; 6 and 7 are read only
  always_ff @(posedge clk) begin
    if (rst) begin
      slew_increment_r    <= 32'h0000_0000;
      slew_complement_r   <= 32'h0000_0000;
      sample_divide_sel_r <= 8'h04;
      shift_divide_sel_r  <= 8'h01;
      code_len_r          <= 5'h18;
    end else if (wr_port && ptr_mode) begin
      unique case (ptr)
        stpc_pkg::HR_INC_LO:   slew_increment_r[15:0]  <= w_data_r[15:0];
        stpc_pkg::HR_INC_HI:   slew_increment_r[31:16] <= w_data_r[15:0];
        stpc_pkg::HR_CMP_LO:   slew_complement_r[15:0] <= w_data_r[15:0];
        stpc_pkg::HR_CMP_HI:   slew_complement_r[31:16] <= w_data_r[15:0];
        stpc_pkg::HR_DIV_SEL: begin
          sample_divide_sel_r <= w_data_r[7:0];
          shift_divide_sel_r  <= w_data_r[15:8];
        end
        stpc_pkg::HR_CODE_SEL: code_len_r <= w_data_r[4:0];
        default: ;
      endcase
    end
  end

  // read channel
  logic [15:0] hold_rd;
  always_comb begin
    hold_rd = 16'h0000;
    unique case (ptr)
      stpc_pkg::HR_INC_LO:   hold_rd = slew_increment_r[15:0];
      stpc_pkg::HR_INC_HI:   hold_rd = slew_increment_r[31:16];
      stpc_pkg::HR_CMP_LO:   hold_rd = slew_complement_r[15:0];
      stpc_pkg::HR_CMP_HI:   hold_rd = slew_complement_r[31:16];
      stpc_pkg::HR_DIV_SEL:  hold_rd = {shift_divide_sel_r, sample_divide_sel_r};
      stpc_pkg::HR_CODE_SEL: hold_rd = {11'h000, code_len_r};
      stpc_pkg::HR_WCNT_LO:  hold_rd = word_count_r[15:0];
      stpc_pkg::HR_WCNT_HI:  hold_rd = word_count_r[31:16];
      default:               hold_rd = 16'h0000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= stpc_pkg::AXI_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_known(s_axi_araddr) && (s_axi_araddr != stpc_pkg::OFF_WRITE_PORT)
                      ? stpc_pkg::AXI_OKAY : stpc_pkg::AXI_SLVERR;
      unique case (s_axi_araddr)
        stpc_pkg::OFF_HOST_CARD:  s_axi_rdata <= {16'h0000, host_card_control_reg_r};
        stpc_pkg::OFF_READ_PORT:  s_axi_rdata <= {16'h0000,
                                  ctl_mode ? coder_control_reg_r : hold_rd};
        stpc_pkg::OFF_STRAPS:     s_axi_rdata <= {31'h0000_0000, irq_r};
        default:                  s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // number-controlled oscillator, one step per chip
  logic [31:0] fb_r;
  logic [31:0] nco_sum;
  logic        first_r;
  logic        adj_req_r;
  logic        chip_en;
  assign nco_sum = fb_r + (first_r ? cmp_act_r : inc_act_r);
  always_ff @(posedge clk) begin
    if (rst) begin
      fb_r      <= 32'h0000_0000;
      first_r   <= 1'b1;
      adj_req_r <= 1'b0;
      inc_act_r <= 32'h0000_0000;
      cmp_act_r <= 32'h0000_0000;
    end else if (sp_tick) begin
      fb_r      <= 32'h0000_0000;
      inc_act_r <= slew_increment_r;
      cmp_act_r <= slew_complement_r;
      first_r   <= 1'b1;
      adj_req_r <= 1'b0;
    end else if (chip_en) begin
      fb_r      <= nco_sum;
      first_r   <= (nco_sum > CMP_REF);
      adj_req_r <= (nco_sum > CMP_REF);
    end
  end

  // divide by 4/5/6 on the 50 MHz enable; increment sign picks add or drop
  logic [2:0] div_cnt_r;
  logic [2:0] div_top;
  assign div_top = !adj_req_r ? 3'(stpc_pkg::CHIP_DIV_NOM)
                 : (inc_act_r[31] ? 3'(stpc_pkg::CHIP_DIV_LONG)
                                  : 3'(stpc_pkg::CHIP_DIV_SHORT));
  assign chip_en = cnt_en_r && (div_cnt_r == div_top - 3'h1);
  always_ff @(posedge clk) begin
    if (rst || sp_tick) begin
      div_cnt_r <= 3'h0;
    end else if (cnt_en_r) begin
      div_cnt_r <= chip_en ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  // divide by n (oversample) and by m (shift clock)
  logic [7:0] n_cnt_r;
  logic [7:0] m_cnt_r;
  logic       shift_en;
  assign shift_en = chip_en && (m_cnt_r >= shift_divide_sel_r - 8'h01);
  always_ff @(posedge clk) begin
    if (rst || sp_tick) begin
      n_cnt_r           <= 8'h00;
      m_cnt_r           <= 8'h00;
      oversample_strobe <= 1'b0;
    end else begin
      oversample_strobe <= 1'b0;
      if (chip_en) begin
        m_cnt_r <= shift_en ? 8'h00 : m_cnt_r + 8'h01;
        if (n_cnt_r >= sample_divide_sel_r - 8'h01) begin
          n_cnt_r           <= 8'h00;
          oversample_strobe <= 1'b1;
        end else begin
          n_cnt_r <= n_cnt_r + 8'h01;
        end
      end
    end
  end

  // pn shift register; tap table holds one maximal polynomial per length
  function automatic logic [23:0] taps(input logic [4:0] len);
    unique case (len)
      5'd2:  taps = 24'h000003;
      5'd3:  taps = 24'h000006;
      5'd4:  taps = 24'h00000C;
      5'd5:  taps = 24'h000014;
      5'd6:  taps = 24'h000030;
      5'd7:  taps = 24'h000060;
      5'd8:  taps = 24'h0000B8;
      5'd9:  taps = 24'h000110;
      5'd10: taps = 24'h000240;
      5'd11: taps = 24'h000500;
      5'd12: taps = 24'h000829;
      5'd13: taps = 24'h00100D;
      5'd14: taps = 24'h002015;
      5'd15: taps = 24'h006000;
      5'd16: taps = 24'h00D008;
      5'd17: taps = 24'h012000;
      5'd18: taps = 24'h020400;
      5'd19: taps = 24'h040023;
      5'd20: taps = 24'h090000;
      5'd21: taps = 24'h140000;
      5'd22: taps = 24'h300000;
      5'd23: taps = 24'h420000;
      default: taps = 24'hE10000;
    endcase
  endfunction
  logic [23:0] lfsr_r;
  logic [23:0] len_mask;
  logic        fb_bit;
  assign len_mask = 24'hFFFFFF >> (5'd24 - ((code_len_r < 5'd2 || code_len_r > 5'd24)
                                   ? 5'd24 : code_len_r));
  assign fb_bit = ^(lfsr_r & taps(code_len_r));
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_r  <= 24'hFFFFFF;
      pn_chip <= 1'b0;
    end else if (sp_tick) begin
      lfsr_r  <= 24'hFFFFFF; // output bit holds, so a second pulse never cuts a chip short
    end else if (shift_en) begin
      lfsr_r  <= {lfsr_r[22:0], fb_bit} & len_mask;
      pn_chip <= lfsr_r[0];
    end
  end

  // word detect: prior state then all ones
  logic [23:0] prior_state;
  logic        prior_seen_r;
  logic        detect;
  assign prior_state = (len_mask >> 1);
  assign detect = shift_en && prior_seen_r && ((lfsr_r & len_mask) == prior_state);
  logic        armed_r;
  always_ff @(posedge clk) begin
    if (rst || sp_tick) begin
      prior_seen_r <= 1'b0;
    end else if (shift_en) begin
      prior_seen_r <= 1'b1;
    end
  end

  // word counter and interrupt
  logic clr_me;
  assign clr_me = wr_port && ctl_mode && w_data_r[stpc_pkg::CLRINT_BIT]
                  && (w_data_r[stpc_pkg::SEL_LSB +: 2] == 2'(CODER_ID));
  always_ff @(posedge clk) begin
    if (rst) begin
      word_count_r <= 32'h0000_0000;
      armed_r      <= 1'b0;
    end else if (sp_tick) begin
      word_count_r <= 32'h0000_0000;
      armed_r      <= 1'b1;
    end else if (detect && armed_r) begin
      armed_r <= 1'b0;
    end else if (armed_r && cnt_en_r) begin
      word_count_r <= word_count_r + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (detect && armed_r) begin
      irq_r <= 1'b1;
    end else if (clr_me) begin
      irq_r <= 1'b0;
    end
  end
  // open collector: enable low pulls line low while request pending and unmasked
  always_ff @(posedge clk) begin
    if (rst) begin
      coder_request_line      <= 1'b0;
      coder_request_line_oe_n <= 1'b1;
      host_interrupt_first    <= 1'b0;
    end else begin
      coder_request_line      <= 1'b0;
      coder_request_line_oe_n <= !(irq_r && coder_control_reg_r[stpc_pkg::MASK_LSB + CODER_ID]);
      host_interrupt_first    <= irq_r && coder_control_reg_r[stpc_pkg::MASK_LSB + CODER_ID];
    end
  end
endmodule // stpc_top

// File: sim/stpc_checker.sv
// stpc_checker: port assertions for one slewed coder
// assumes it is bound into stpc_top and sees only its ports
`timescale 1ns/1ps
module stpc_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        coder_request_line,
  input wire logic        coder_request_line_oe_n,
  input wire logic        host_interrupt_first,
  input wire logic        pn_chip,
  input wire logic        oversample_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bresp_hold_a :
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  rdata_hold_a :
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  ar_refuse_a :
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  aw_refuse_a :
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
  rd_answer_a :
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  rd_port_err_a :
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == stpc_pkg::OFF_WRITE_PORT
      |=> s_axi_rresp == stpc_pkg::AXI_SLVERR) else $error("write port readable");
  line_low_a :
    assert property (coder_request_line == 1'h0) else $error("request line driven high");
  irq_copy_a :
    assert property (host_interrupt_first == !coder_request_line_oe_n)
      else $error("card interrupt differs from request");
  strobe_pulse_a :
    assert property (oversample_strobe |=> !oversample_strobe) else $error("strobe too long");
  chip_space_a :
    assert property ($changed(pn_chip) |=> $stable(pn_chip) [*3]) else $error("chip too fast");
endmodule // stpc_checker

bind stpc_top stpc_checker i_stpc_checker (.clk, .rst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .coder_request_line,
  .coder_request_line_oe_n, .host_interrupt_first, .pn_chip, .oversample_strobe);

// File: sim/stpc_host_model.sv
// stpc_host_model: axi4-lite host reaching the coder registers
// assumes one clock; the request line carries a pull-up on the host card
`timescale 1ns/1ps
module stpc_host_model (
  input  wire logic        clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic        coder_request_line,
  input  wire logic        coder_request_line_oe_n,
  output logic             req_level
);
  // open collector: only a sinking coder beats the pull-up
  assign req_level = coder_request_line_oe_n ? 1'h1 : coder_request_line;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    s_axi_wdata = 32'h0000_0000;
  end
  // write port and read port are reached at separate addresses
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
endmodule // stpc_host_model

// File: sim/slewed_timebase_pn_coder_tb.sv
// slewed_timebase_pn_coder_tb: register table, interrupt and reset tests
// assumes stpc_top with CODER_ID 0 and the host model on its bus
`timescale 1ns/1ps
module slewed_timebase_pn_coder_tb;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } stpc_row_t;
  localparam logic [1:0] OK = stpc_pkg::AXI_OKAY;
  localparam logic [1:0] ER = stpc_pkg::AXI_SLVERR;
  localparam int         N_ROWS = 23;
  logic        clk, rst, second_pulse, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, coder_request_line, coder_request_line_oe_n;
  logic        host_interrupt_first, pn_chip, oversample_strobe, req_level;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, cnt_a;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          err_total = 0, comparisons = 0, cycles = 0, n_strobe = 0;
  // mode 01 rows load increment, complement of increment plus frequency, dividers, length
  // mode 10 rows: port write ignored, read stays on the pointer without advancing
  stpc_row_t   rows [N_ROWS] = '{'{1'h0, 8'h00, 32'h0, OK}, '{1'h0, 8'h08, 32'h0, OK},
    '{1'h1, 8'h04, 32'h10, OK}, '{1'h0, 8'h08, 32'h10, OK}, '{1'h0, 8'h04, 32'h0, ER},
    '{1'h0, 8'h40, 32'h0, ER}, '{1'h1, 8'h08, 32'h1, ER}, '{1'h1, 8'h00, 32'h1, OK},
    '{1'h1, 8'h04, 32'h0, OK}, '{1'h1, 8'h04, 32'h0, OK}, '{1'h1, 8'h04, 32'h9680, OK},
    '{1'h1, 8'h04, 32'h98, OK}, '{1'h1, 8'h04, 32'h101, OK}, '{1'h1, 8'h04, 32'h2, OK},
    '{1'h1, 8'h00, 32'h0, OK}, '{1'h1, 8'h04, 32'h14, OK}, '{1'h1, 8'h00, 32'h1, OK},
    '{1'h0, 8'h08, 32'h101, OK}, '{1'h1, 8'h00, 32'h2, OK}, '{1'h1, 8'h04, 32'h7, OK},
    '{1'h0, 8'h08, 32'h2, OK}, '{1'h1, 8'h00, 32'h1, OK}, '{1'h0, 8'h08, 32'h2, OK}};
  stpc_top i_stpc_top (.clk, .rst, .second_pulse, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coder_request_line,
    .coder_request_line_oe_n, .host_interrupt_first, .pn_chip, .oversample_strobe);
  stpc_host_model i_stpc_host_model (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coder_request_line,
    .coder_request_line_oe_n, .req_level);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (!ok) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_stpc_host_model.wr(a, d, rsp);
  endtask
  task automatic stat(input logic e);
    i_stpc_host_model.rd(stpc_pkg::OFF_STRAPS, rd_d, rsp);
    chk(rd_d[0] === e, "pending flag");
  endtask
  // second pulse held long enough to pass the input filter
  task automatic pulse();
    @(posedge clk);
    second_pulse <= 1'h1;
    repeat (20) @(posedge clk);
    second_pulse <= 1'h0;
    repeat (400) @(posedge clk);
  endtask
  // ceiling well above the thousand or so cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end
  initial begin
    rst = 1'h1;
    second_pulse = 1'h0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(s_axi_bvalid === 1'h0 && s_axi_rvalid === 1'h0
        && coder_request_line_oe_n === 1'h1, "reset outputs");
    for (int i = 0; i < N_ROWS; i++) begin
      if (rows[i].wr) i_stpc_host_model.wr(rows[i].addr, rows[i].data, rsp);
      else i_stpc_host_model.rd(rows[i].addr, rd_d, rsp);
      chk(rsp === rows[i].resp, "response code");
      if (!rows[i].wr && rsp === OK) chk(rd_d === rows[i].data, "read data");
    end
    $display("table test done");
    w(8'h00, 32'h0);
    w(8'h04, 32'h20);
    w(8'h04, 32'h206);
    pulse();
    stat(1'h1);
    chk(coder_request_line_oe_n === 1'h0 && req_level === 1'h0, "line not sunk");
    chk(host_interrupt_first === 1'h1, "card interrupt");
    w(8'h00, 32'h1);
    i_stpc_host_model.rd(8'h08, cnt_a, rsp);
    w(8'h04, 32'hFFFF);
    // no slewing: one chip per five 50 MHz ticks, one strobe per chip with n of one
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      n_strobe += oversample_strobe;
    end
    chk(n_strobe === 10, "strobe count");
    i_stpc_host_model.rd(8'h08, rd_d, rsp);
    // length 2 code reaches all ones on the third chip; the detecting tick is not counted
    chk(rd_d === cnt_a && cnt_a === 32'(3 * stpc_pkg::CHIP_DIV_NOM - 1),
        "word count moved");
    w(8'h00, 32'h0);
    w(8'h04, 32'h66);
    repeat (4) @(posedge clk);
    chk(coder_request_line_oe_n === 1'h1, "masked line sunk");
    stat(1'h1);
    w(8'h04, 32'h26);
    stat(1'h0);
    pulse();
    stat(1'h1);
    w(8'h00, 32'h1);
    i_stpc_host_model.rd(8'h08, rd_d, rsp);
    chk(rd_d === cnt_a, "word count not restarted");
    $display("interrupt test done");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    stat(1'h0);
    chk(coder_request_line_oe_n === 1'h1, "line after reset");
    $display("reset test done");
    end_of_test();
  end
endmodule // slewed_timebase_pn_coder_tb
